// >>> pkg/gpm_cfg.svh
/*
 Constants of the generator protection monitor: register offsets, option
 field positions, anomaly codes and timing counts. Assumes a 100 MHz clock.
*/
`ifndef GPM_CFG_SVH
`define GPM_CFG_SVH

`define GPM_REG_PASSWORD 16'h0065
`define GPM_REG_CODE 16'h0066
`define GPM_CODE_STOP 16'h0016

`define GPM_AIN_CODE_BASE 16'h012D
`define GPM_AIN_CODE_NONE 16'h0000

`define GPM_OPT_ENABLE 0
`define GPM_OPT_HIGH 1
`define GPM_OPT_FUEL 2
`define GPM_KBD_NO_STOP 0

`define GPM_EXC_FUNC 16'h0514

`define GPM_CLK_PERIOD_NS 10
`define GPM_TICK_NS 1000000
`define GPM_TICK_CYCLES (`GPM_TICK_NS / `GPM_CLK_PERIOD_NS)
`define GPM_REMOTE_WIN_S 5
`define GPM_REMOTE_WIN_TICKS (`GPM_REMOTE_WIN_S * 1000)
`define GPM_PCT_FULL 100

`endif

// >>> pkg/gpm_pkg.sv
/*
 Types of the generator protection monitor. Assumes gpm_cfg.svh for numbers.
*/
package gpm_pkg;
  typedef enum logic [1:0] {
    GPM_OFF,
    GPM_MAN,
    GPM_AUTO,
    GPM_TEST
  } gpm_mode_t;

  typedef enum logic {
    GPM_RS_IDLE,
    GPM_RS_ARMED
  } gpm_rs_state_t;

  typedef logic [15:0] gpm_word_t;
endpackage : gpm_pkg

// >>> hw/gpm_persist.sv
/*
 Persistence timer: raises a latched trip when a cause stays present for a
 delay counted in ticks. Assumes a one-cycle tick enable from the parent.
*/
`timescale 1ns/10ps
`include "gpm_cfg.svh"
module gpm_persist import gpm_pkg::*; #(
  parameter int W = 16,
  parameter bit ZERO_OFF = 1'b1
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic tick_i,
  input wire logic en_i,
  input wire logic cond_i,
  input wire logic [W-1:0] delay_i,
  output logic trip_o
);
  logic [W-1:0] cnt_q, cnt_d;
  logic trip_q, trip_d;
  logic [W:0] cnt_inc;

  assign cnt_inc = {1'b0, cnt_q} + {{W{1'b0}}, 1'b1};

  always_comb begin
    cnt_d = cnt_q;
    trip_d = trip_q;
    if (!en_i) begin
      cnt_d = '0;
      trip_d = 1'b0;
    end else if (!cond_i) begin
      cnt_d = '0;
    end else if (delay_i == '0) begin
      if (!ZERO_OFF) begin
        trip_d = 1'b1;
      end
    end else if (tick_i && !trip_q) begin
      if (cnt_inc >= {1'b0, delay_i}) begin
        trip_d = 1'b1;
      end else begin
        cnt_d = cnt_inc[W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_q <= '0;
      trip_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      trip_q <= trip_d;
    end
  end

  assign trip_o = trip_q;

  zero_delay_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (en_i && cond_i && delay_i == '0 && !ZERO_OFF) |=> trip_o) else $error("zero delay did not trip");
  timer_restart_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (en_i && !cond_i) |=> (cnt_q == '0)) else $error("timer not restarted");
  no_cause_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (!en_i) |=> !trip_o) else $error("trip while disabled");
endmodule : gpm_persist

// >>> hw/gpm_top.sv
/*
 Generator protection monitor: analogue thresholds, generator voltage,
 alternator, inverse-time overcurrent, manual stop and operating conditions.
 Assumes measurements and settings arrive synchronous to clk_i.
*/
`timescale 1ns/10ps
`include "gpm_cfg.svh"
module gpm_top import gpm_pkg::*; #(
  parameter int N_AIN = 5,
  parameter int TICK_CYC = `GPM_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [1:0] mode_i,
  input wire logic drive_app_i,
  input wire logic fuel_open_i,
  input wire logic start_stop_i,
  input wire logic loads_on_i,
  input wire logic speed_ok_i,
  input wire logic volt_ok_i,
  input wire logic run_ref_i,
  input wire logic [16*N_AIN-1:0] ain_value_i,
  input wire logic [32*N_AIN-1:0] thr_level_i,
  input wire logic [32*N_AIN-1:0] thr_delay_i,
  input wire logic [16*N_AIN-1:0] thr_opt_i,
  input wire logic [15:0] gen_volt_i,
  input wire logic [15:0] low_volt_lvl_i,
  input wire logic [15:0] low_volt_dly_i,
  input wire logic [15:0] high_volt_lvl_i,
  input wire logic [15:0] high_volt_dly_i,
  input wire logic [15:0] exc_func_i,
  input wire logic [15:0] exc_volt_i,
  input wire logic [15:0] exc_stop_lvl_i,
  input wire logic [15:0] alt_dly_i,
  input wire logic [1:0] alt_action_i,
  input wire logic [15:0] gen_cur_i,
  input wire logic [15:0] rated_cur_i,
  input wire logic [15:0] oc_pct_i,
  input wire logic [15:0] oc_time_i,
  input wire logic [1:0] oc_action_i,
  input wire logic [15:0] opc_max_i,
  input wire logic [15:0] kbd_opt_i,
  input wire logic stop_key_i,
  input wire logic [15:0] password_i,
  input wire logic mb_wr_i,
  input wire logic [15:0] mb_addr_i,
  input wire logic [15:0] mb_data_i,
  output logic [2*N_AIN-1:0] ain_anom_o,
  output logic [2*N_AIN-1:0] ain_high_o,
  output logic [15:0] ain_code_o,
  output logic low_volt_anom_o,
  output logic high_volt_anom_o,
  output logic alt_anom_o,
  output logic [1:0] alt_type_o,
  output logic oc_anom_o,
  output logic [1:0] oc_type_o,
  output logic man_stop_o,
  output logic opc_anom_o
);
  localparam int NT = 2 * N_AIN;
  localparam int TW = $clog2(TICK_CYC + 1);

  gpm_mode_t mode;
  logic mode_run, is_auto, is_man;
  assign mode = gpm_mode_t'(mode_i);
  assign mode_run = (mode == GPM_MAN) || (mode == GPM_AUTO);
  assign is_auto = (mode == GPM_AUTO);
  assign is_man = (mode == GPM_MAN);

  // Tick divider, 1 ms
  logic [TW-1:0] div_q, div_d;
  logic tick_q, tick_d;
  always_comb begin
    tick_d = (div_q == TW'(TICK_CYC - 1));
    div_d = tick_d ? '0 : div_q + TW'(1);
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  // Analogue thresholds, two per input
  logic [NT-1:0] ain_en, ain_cond;
  logic [NT-1:0] ain_high_q, ain_high_d;
  genvar g;
  generate
    for (g = 0; g < NT; g++) begin : g_thr
      logic [15:0] meas, lvl;
      logic [7:0] opt;
      assign meas = ain_value_i[16*(g/2) +: 16];
      assign lvl = thr_level_i[16*g +: 16];
      assign opt = thr_opt_i[8*g +: 8];
      assign ain_en[g] = opt[`GPM_OPT_ENABLE] && (!opt[`GPM_OPT_FUEL] || fuel_open_i);
      assign ain_cond[g] = opt[`GPM_OPT_HIGH] ? (meas > lvl) : (meas < lvl);
      assign ain_high_d[g] = opt[`GPM_OPT_HIGH];
      gpm_persist #(.W(16), .ZERO_OFF(1'b0)) u_thr (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .tick_i(tick_q),
        .en_i(ain_en[g]),
        .cond_i(ain_cond[g]),
        .delay_i(thr_delay_i[16*g +: 16]),
        .trip_o(ain_anom_o[g])
      );
    end
  endgenerate

  function automatic logic [15:0] ain_code(input logic [NT-1:0] act);
    logic [15:0] code;
    code = `GPM_AIN_CODE_NONE;
    for (int i = NT - 1; i >= 0; i--) begin
      if (act[i]) begin
        code = `GPM_AIN_CODE_BASE + 16'(i);
      end
    end
    return code;
  endfunction : ain_code

  logic [15:0] ain_code_q, ain_code_d;
  always_comb begin
    ain_code_d = ain_code(ain_anom_o);
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ain_code_q <= `GPM_AIN_CODE_NONE;
      ain_high_q <= '0;
    end else begin
      ain_code_q <= ain_code_d;
      ain_high_q <= ain_high_d;
    end
  end
  assign ain_code_o = ain_code_q;
  assign ain_high_o = ain_high_q;

  // Generator voltage protections
  logic gen_base, bands_q, bands_d, lowv_en, highv_en;
  // voltage and current not for drive
  assign gen_base = mode_run && !drive_app_i && fuel_open_i && !start_stop_i;
  always_comb begin
    bands_d = bands_q;
    if (!fuel_open_i) begin
      bands_d = 1'b0;
    end else if (speed_ok_i && volt_ok_i) begin
      bands_d = 1'b1;
    end
  end
  assign lowv_en = gen_base && bands_q && (!is_man || loads_on_i);
  assign highv_en = gen_base;

  gpm_persist #(.W(16), .ZERO_OFF(1'b1)) u_lowv (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .tick_i(tick_q),
    .en_i(lowv_en),
    .cond_i(gen_volt_i < low_volt_lvl_i),
    .delay_i(low_volt_dly_i),
    .trip_o(low_volt_anom_o)
  );
  gpm_persist #(.W(16), .ZERO_OFF(1'b1)) u_highv (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .tick_i(tick_q),
    .en_i(highv_en),
    .cond_i(gen_volt_i > high_volt_lvl_i),
    .delay_i(high_volt_dly_i),
    .trip_o(high_volt_anom_o)
  );

  logic alt_en;
  assign alt_en = mode_run && fuel_open_i && (exc_func_i == `GPM_EXC_FUNC);
  gpm_persist #(.W(16), .ZERO_OFF(1'b1)) u_alt (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .tick_i(tick_q),
    .en_i(alt_en),
    .cond_i(exc_volt_i < exc_stop_lvl_i),
    .delay_i(alt_dly_i),
    .trip_o(alt_anom_o)
  );

  // Inverse-time overcurrent
  logic [31:0] oc_ith;
  logic [63:0] oc_isq, oc_thsq, oc_lim;
  logic [63:0] oc_acc_q, oc_acc_d;
  logic oc_q, oc_d, oc_en, oc_over;
  logic [1:0] alt_type_q, oc_type_q;
  assign oc_ith = (32'(rated_cur_i) * 32'(oc_pct_i)) / 32'(`GPM_PCT_FULL);
  assign oc_isq = 64'(gen_cur_i) * 64'(gen_cur_i);
  assign oc_thsq = 64'(oc_ith) * 64'(oc_ith);
  assign oc_lim = 64'(oc_thsq * 64'(oc_time_i));
  assign oc_over = (32'(gen_cur_i) > oc_ith);
  assign oc_en = gen_base && (oc_time_i != 16'h0000);
  always_comb begin
    oc_acc_d = oc_acc_q;
    oc_d = oc_q;
    if (!oc_en) begin
      oc_acc_d = '0;
      oc_d = 1'b0;
    end else if (!oc_over) begin
      oc_acc_d = '0;
    end else if (tick_q && !oc_q) begin
      oc_acc_d = oc_acc_q + (oc_isq - oc_thsq);
      if (oc_acc_d >= oc_lim) begin
        oc_d = 1'b1;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      oc_acc_q <= '0;
      oc_q <= 1'b0;
      bands_q <= 1'b0;
      alt_type_q <= 2'h0;
      oc_type_q <= 2'h0;
    end else begin
      oc_acc_q <= oc_acc_d;
      oc_q <= oc_d;
      bands_q <= bands_d;
      alt_type_q <= alt_action_i;
      oc_type_q <= oc_action_i;
    end
  end
  assign oc_anom_o = oc_q;
  assign alt_type_o = alt_type_q;
  assign oc_type_o = oc_type_q;

  // Manual stop: key or remote sequence
  gpm_rs_state_t rs_q, rs_d;
  logic [15:0] rs_cnt_q, rs_cnt_d;
  logic stop_q, stop_d, stop_en, pw_wr, code_wr, win_end;
  assign pw_wr = mb_wr_i && (mb_addr_i == `GPM_REG_PASSWORD);
  assign code_wr = mb_wr_i && (mb_addr_i == `GPM_REG_CODE);
  assign stop_en = is_auto && !kbd_opt_i[`GPM_KBD_NO_STOP];
  assign win_end = tick_q && (rs_cnt_q >= 16'(`GPM_REMOTE_WIN_TICKS - 1));
  always_comb begin
    rs_d = rs_q;
    rs_cnt_d = rs_cnt_q;
    stop_d = stop_q;
    if (!is_auto) begin
      stop_d = 1'b0;
    end else if (stop_en && stop_key_i) begin
      stop_d = 1'b1;
    end
    case (rs_q)
      GPM_RS_IDLE: begin
        if (pw_wr && mb_data_i == password_i) begin
          rs_d = GPM_RS_ARMED;
          rs_cnt_d = 16'h0000;
        end
      end
      GPM_RS_ARMED: begin
        if (pw_wr) begin
          rs_d = (mb_data_i == password_i) ? GPM_RS_ARMED : GPM_RS_IDLE;
          rs_cnt_d = 16'h0000;
        end else if (code_wr) begin
          rs_d = GPM_RS_IDLE;
          if (mb_data_i == `GPM_CODE_STOP && stop_en) begin
            stop_d = 1'b1;
          end
        end else if (win_end) begin
          rs_d = GPM_RS_IDLE;
        end else if (tick_q) begin
          rs_cnt_d = rs_cnt_q + 16'h0001;
        end
      end
      default: rs_d = GPM_RS_IDLE;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rs_q <= GPM_RS_IDLE;
      rs_cnt_q <= 16'h0000;
      stop_q <= 1'b0;
    end else begin
      rs_q <= rs_d;
      rs_cnt_q <= rs_cnt_d;
      stop_q <= stop_d;
    end
  end
  assign man_stop_o = stop_q;

  // Operating conditions not reached
  logic opc_en, settled_q, settled_d;
  assign opc_en = fuel_open_i && (is_auto || (is_man && drive_app_i));
  always_comb begin
    settled_d = settled_q;
    if (!opc_en || !run_ref_i) begin
      settled_d = 1'b0;
    end else if (speed_ok_i && volt_ok_i) begin
      settled_d = 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      settled_q <= 1'b0;
    end else begin
      settled_q <= settled_d;
    end
  end
  gpm_persist #(.W(16), .ZERO_OFF(1'b1)) u_opc (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .tick_i(tick_q),
    .en_i(opc_en && run_ref_i),
    .cond_i(!settled_d),
    .delay_i(opc_max_i),
    .trip_o(opc_anom_o)
  );

  sequence pw_ok_s;
    pw_wr && (mb_data_i == password_i);
  endsequence
  sequence code_stop_s;
    code_wr && (mb_data_i == `GPM_CODE_STOP) && stop_en;
  endsequence

  lowv_gate_a: assert property (@(posedge clk_i) disable iff (srst_i)
    !lowv_en |=> !low_volt_anom_o) else $error("low voltage while not enabled");
  highv_gate_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (start_stop_i || !fuel_open_i) |=> !high_volt_anom_o) else $error("high voltage in start or stop");
  drive_block_a: assert property (@(posedge clk_i) disable iff (srst_i)
    drive_app_i |=> !(oc_anom_o || low_volt_anom_o || high_volt_anom_o)) else $error("protection in drive");
  mode_only_a: assert property (@(posedge clk_i) disable iff (srst_i)
    !mode_run |=> !(alt_anom_o || oc_anom_o)) else $error("protection outside run modes");
  key_stop_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (stop_en && stop_key_i) |=> man_stop_o) else $error("stop key ignored");
  stop_cause_a: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(man_stop_o) |-> $past(stop_en)) else $error("stop with option set");
  remote_stop_a: assert property (@(posedge clk_i) disable iff (srst_i)
    pw_ok_s ##1 (!pw_wr && !code_wr) [*4] ##1 code_stop_s |=> man_stop_o) else $error("remote stop lost");
  remote_late_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (rs_q == GPM_RS_ARMED && win_end && !mb_wr_i) |=> (rs_q == GPM_RS_IDLE)) else $error("window not closed");
  oc_below_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (oc_en && !oc_over) |=> (oc_acc_q == '0) && ($past(oc_q) == oc_q)) else $error("overcurrent below threshold");
  ain_code_a: assert property (@(posedge clk_i) disable iff (srst_i)
    ain_anom_o[0] |=> (ain_code_o == `GPM_AIN_CODE_BASE)) else $error("wrong analogue code");
endmodule : gpm_top

// >>> dv/gpm_master.sv
/*
 Partner model: a Modbus master that issues holding-register writes.
 Assumes the bench calls its tasks and shares clk_i with the monitor.
*/
`timescale 1ns/10ps
`include "gpm_cfg.svh"
module gpm_master (
  input wire logic clk_i,
  output logic mb_wr_o,
  output logic [15:0] mb_addr_o,
  output logic [15:0] mb_data_o
);
  initial begin
    mb_wr_o = 1'b0;
    mb_addr_o = 16'h0000;
    mb_data_o = 16'h0000;
  end

  // Idle bus shows the inverse of the last write
  task automatic write(input logic [15:0] addr, input logic [15:0] data);
    @(posedge clk_i);
    #1;
    mb_wr_o = 1'b1;
    mb_addr_o = addr;
    mb_data_o = data;
    @(posedge clk_i);
    #1;
    mb_wr_o = 1'b0;
    mb_addr_o = ~addr;
    mb_data_o = ~data;
  endtask : write

  task automatic remote_stop(input logic [15:0] pw, input int gap);
    write(`GPM_REG_PASSWORD, pw);
    repeat (gap) @(posedge clk_i);
    write(`GPM_REG_CODE, `GPM_CODE_STOP);
  endtask : remote_stop
endmodule : gpm_master

// >>> dv/testbench.sv
/*
 Self-checking bench of the protection monitor, one task per scenario.
 Assumes a 10-cycle tick parameter and the partner master model.
*/
`timescale 1ns/10ps
`include "gpm_cfg.svh"
module testbench import gpm_pkg::*;;
  localparam int TCK = 10;
  localparam int LIMIT = 60000;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [1:0] mode_i;
  logic drive_app_i, fuel_open_i, start_stop_i, loads_on_i, speed_ok_i, volt_ok_i, run_ref_i, stop_key_i;
  logic [79:0] ain_value_i, thr_opt_i;
  logic [159:0] thr_level_i, thr_delay_i;
  logic [15:0] gen_volt_i, low_volt_lvl_i, low_volt_dly_i, high_volt_lvl_i, high_volt_dly_i, exc_func_i;
  logic [15:0] exc_volt_i, exc_stop_lvl_i, alt_dly_i, gen_cur_i, rated_cur_i, oc_pct_i, oc_time_i;
  logic [15:0] opc_max_i, kbd_opt_i, password_i, mb_addr_i, mb_data_i, ain_code_o;
  logic [1:0] alt_action_i, oc_action_i, alt_type_o, oc_type_o;
  logic mb_wr_i, low_volt_anom_o, high_volt_anom_o, alt_anom_o, oc_anom_o, man_stop_o, opc_anom_o;
  logic [9:0] ain_anom_o, ain_high_o;
  int err_count = 0;
  int n_checks = 0;
  int cyc_cnt = 0;

  always #5 clk_i = ~clk_i;

  gpm_master u_master (.clk_i(clk_i), .mb_wr_o(mb_wr_i), .mb_addr_o(mb_addr_i), .mb_data_o(mb_data_i));

  gpm_top #(.N_AIN(5), .TICK_CYC(TCK)) i_gpm_top (
    .clk_i(clk_i), .srst_i(srst_i), .mode_i(mode_i), .drive_app_i(drive_app_i), .fuel_open_i(fuel_open_i),
    .start_stop_i(start_stop_i), .loads_on_i(loads_on_i), .speed_ok_i(speed_ok_i), .volt_ok_i(volt_ok_i),
    .run_ref_i(run_ref_i), .ain_value_i(ain_value_i), .thr_level_i(thr_level_i), .thr_delay_i(thr_delay_i),
    .thr_opt_i(thr_opt_i), .gen_volt_i(gen_volt_i), .low_volt_lvl_i(low_volt_lvl_i),
    .low_volt_dly_i(low_volt_dly_i), .high_volt_lvl_i(high_volt_lvl_i), .high_volt_dly_i(high_volt_dly_i),
    .exc_func_i(exc_func_i), .exc_volt_i(exc_volt_i), .exc_stop_lvl_i(exc_stop_lvl_i), .alt_dly_i(alt_dly_i),
    .alt_action_i(alt_action_i), .gen_cur_i(gen_cur_i), .rated_cur_i(rated_cur_i), .oc_pct_i(oc_pct_i),
    .oc_time_i(oc_time_i), .oc_action_i(oc_action_i), .opc_max_i(opc_max_i), .kbd_opt_i(kbd_opt_i),
    .stop_key_i(stop_key_i), .password_i(password_i), .mb_wr_i(mb_wr_i), .mb_addr_i(mb_addr_i),
    .mb_data_i(mb_data_i), .ain_anom_o(ain_anom_o), .ain_high_o(ain_high_o), .ain_code_o(ain_code_o),
    .low_volt_anom_o(low_volt_anom_o), .high_volt_anom_o(high_volt_anom_o), .alt_anom_o(alt_anom_o),
    .alt_type_o(alt_type_o), .oc_anom_o(oc_anom_o), .oc_type_o(oc_type_o), .man_stop_o(man_stop_o),
    .opc_anom_o(opc_anom_o));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc

  task automatic restart(input int n);
    srst_i = 1'b1;
    mode_i = GPM_AUTO;
    {drive_app_i, start_stop_i, run_ref_i, stop_key_i} = 4'h0;
    {fuel_open_i, loads_on_i, speed_ok_i, volt_ok_i} = 4'hF;
    {ain_value_i, thr_opt_i, thr_level_i, thr_delay_i, alt_action_i, oc_action_i} = '0;
    {low_volt_lvl_i, low_volt_dly_i, high_volt_dly_i, exc_func_i, exc_volt_i, exc_stop_lvl_i} = '0;
    {alt_dly_i, gen_cur_i, rated_cur_i, oc_pct_i, oc_time_i, opc_max_i, kbd_opt_i} = '0;
    gen_volt_i = 16'h0100;
    high_volt_lvl_i = 16'hFFFF;
    password_i = 16'h1234;
    cyc(n);
    srst_i = 1'b0;
  endtask : restart

  function automatic logic pick(input int k);
    case (k)
      0: return low_volt_anom_o;
      1: return high_volt_anom_o;
      2: return alt_anom_o;
      3: return oc_anom_o;
      4: return man_stop_o;
      5: return opc_anom_o;
      default: return ain_anom_o[k-8];
    endcase
  endfunction : pick

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s got %h", $time, msg, got);
    end
  endtask : chk_word

  // Flag must rise no sooner than lo and no later than hi cycles
  task automatic expect_rise(input int k, input int lo, input int hi, input string msg);
    int i;
    i = 0;
    while (i < hi && pick(k) !== 1'b1) begin
      cyc(1);
      i++;
    end
    chk_bit(pick(k), 1'b1, msg);
    chk_bit(i >= lo, 1'b1, msg);
  endtask : expect_rise

  task automatic expect_quiet(input int k, input int n, input string msg);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      cyc(1);
      seen = seen | (pick(k) !== 1'b0);
    end
    chk_bit(seen, 1'b0, msg);
  endtask : expect_quiet

  task automatic t_ain();
    restart(2);
    thr_level_i[16*9 +: 16] = 16'h00C8;
    thr_opt_i[8*9 +: 8] = 8'h01;
    thr_opt_i[8*1 +: 8] = 8'h02;
    expect_rise(17, 0, 3, "zero delay low threshold");
    chk_bit(ain_high_o[9], 1'b0, "low direction");
    cyc(1);
    chk_word(ain_code_o, `GPM_AIN_CODE_BASE + 16'h0009, "tenth code");
    thr_level_i[0 +: 16] = 16'h0190;
    thr_delay_i[0 +: 16] = 16'h0003;
    thr_opt_i[0 +: 8] = 8'h03;
    ain_value_i[0 +: 16] = 16'h01F4;
    expect_rise(8, 2*TCK, 4*TCK+3, "delayed high threshold");
    chk_bit(ain_high_o[0], 1'b1, "high direction");
    cyc(1);
    chk_word(ain_code_o, `GPM_AIN_CODE_BASE, "lowest code");
    chk_bit(ain_anom_o[1], 1'b0, "option bit off");
    $display("test ain done");
  endtask : t_ain

  task automatic t_volt();
    restart(2);
    mode_i = GPM_MAN;
    loads_on_i = 1'b0;
    low_volt_lvl_i = 16'h0200;
    low_volt_dly_i = 16'h0002;
    expect_quiet(0, 5*TCK, "low volt needs loads");
    loads_on_i = 1'b1;
    expect_rise(0, TCK, 3*TCK+3, "low volt after delay");
    mode_i = GPM_OFF;
    cyc(2);
    chk_bit(low_volt_anom_o, 1'b0, "off mode drops");
    restart(2);
    low_volt_lvl_i = 16'h0200;
    expect_quiet(0, 5*TCK, "zero low delay");
    high_volt_lvl_i = 16'h0080;
    high_volt_dly_i = 16'h0003;
    repeat (3) begin
      gen_volt_i = 16'h0100;
      cyc(15);
      chk_bit(high_volt_anom_o, 1'b0, "interrupted cause");
      gen_volt_i = 16'h0040;
      cyc(5);
    end
    gen_volt_i = 16'h0100;
    expect_rise(1, 2*TCK, 4*TCK+3, "high volt after delay");
    drive_app_i = 1'b1;
    cyc(2);
    chk_bit(high_volt_anom_o, 1'b0, "drive drops");
    high_volt_dly_i = 16'h0000;
    drive_app_i = 1'b0;
    expect_quiet(1, 6*TCK, "zero high delay");
    $display("test volt done");
  endtask : t_volt

  task automatic t_alt_oc();
    restart(2);
    exc_volt_i = 16'h0010;
    exc_stop_lvl_i = 16'h0020;
    alt_dly_i = 16'h0002;
    alt_action_i = 2'h3;
    expect_quiet(2, 5*TCK, "no excitation input");
    exc_func_i = `GPM_EXC_FUNC;
    expect_rise(2, TCK, 3*TCK+3, "alternator failure");
    chk_word({14'h0000, alt_type_o}, 16'h0003, "alternator type");
    fuel_open_i = 1'b0;
    cyc(2);
    chk_bit(alt_anom_o, 1'b0, "fuel closed drops");
    fuel_open_i = 1'b1;
    rated_cur_i = 16'h0064;
    oc_pct_i = 16'h0064;
    oc_time_i = 16'h0009;
    oc_action_i = 2'h2;
    gen_cur_i = 16'h0064;
    expect_quiet(3, 8*TCK, "current at threshold");
    start_stop_i = 1'b1;
    gen_cur_i = 16'h00C8;
    expect_quiet(3, 6*TCK, "start phase");
    start_stop_i = 1'b0;
    expect_rise(3, 2*TCK, 4*TCK+3, "three tick trip");
    chk_word({14'h0000, oc_type_o}, 16'h0002, "overcurrent type");
    mode_i = GPM_TEST;
    cyc(2);
    chk_bit(oc_anom_o, 1'b0, "test mode drops");
    mode_i = GPM_AUTO;
    gen_cur_i = 16'h012C;
    expect_rise(3, TCK, 2*TCK+3, "two tick trip");
    $display("test alt_oc done");
  endtask : t_alt_oc

  task automatic t_stop();
    restart(2);
    kbd_opt_i = 16'h0001;
    stop_key_i = 1'b1;
    expect_quiet(4, 10, "stop key disabled");
    kbd_opt_i = 16'h0000;
    expect_rise(4, 0, 3, "stop key");
    restart(2);
    u_master.remote_stop(16'h4321, 3);
    expect_quiet(4, 10, "wrong password");
    u_master.remote_stop(16'h1234, 3);
    expect_rise(4, 0, 3, "remote stop");
    restart(2);
    u_master.remote_stop(16'h1234, 5000*TCK+20);
    expect_quiet(4, 10, "late code");
    $display("test stop done");
  endtask : t_stop

  task automatic t_opc();
    restart(2);
    run_ref_i = 1'b1;
    opc_max_i = 16'h0003;
    expect_quiet(5, 6*TCK, "settled in time");
    restart(2);
    speed_ok_i = 1'b0;
    run_ref_i = 1'b1;
    opc_max_i = 16'h0003;
    expect_rise(5, 2*TCK, 4*TCK+3, "not settled");
    mode_i = GPM_MAN;
    expect_quiet(5, 6*TCK, "manual without drive");
    drive_app_i = 1'b1;
    expect_rise(5, 2*TCK, 4*TCK+3, "manual with drive");
    $display("test opc done");
  endtask : t_opc

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == LIMIT) begin
      err_count++;
      $display("FAIL %0t timeout", $time);
      wrap_up();
    end
  end

  initial begin
    restart(12);
    t_ain();
    t_volt();
    t_alt_oc();
    t_stop();
    t_opc();
    wrap_up();
  end
endmodule : testbench
